// File: logic/clock_generator_config.sv
// Purpose: clock generator configuration, gating and status over AHB-Lite
// Assumes: slow and main clocks arrive as pins and are oversampled
// Notes: derived clocks leave as one-cycle enable pulses on clk_sys_in
// Overview of operation
// - a 1 written to the gating set word enables that peripheral clock
// - a 1 written to the gating clear word disables that peripheral clock
// - gating status word reads 1 for each enabled peripheral clock
// - gating writes to unimplemented identifiers change nothing
// - enable bit starts oscillator; stable flag rises after start-up delay
// - skip bit sets the stable flag at once
// - clearing enable and skip bits clears the stable flag
// - start-up delay is delay field times 8 slow clock cycles
// - meter counts main clock cycles within 16 slow periods
// - measurement valid bit low while invalid or oscillator off
// - input divider 0 stops, 1 bypasses, 2 to 255 divides
// - after a pll write, lock flag low for settle delay slow cycles
// - feedback factor 0 stops pll; otherwise output is input times factor+1
// - usb ratio 0 passes, 1 halves, 2 quarters, 3 reserved
// - source 0 slow, 1 main, 3 pll, 2 reserved
// - scaler codes 0 to 6 divide by 1 to 64; 7 reserved
// - with the scaler active a switch takes 64 more new-clock cycles
// - status register shows the pll lock flag
// - status register shows the oscillator stable flag
//
// Our own choices: register access over AHB-Lite and the register offsets.
`default_nettype none
module clock_generator_config
	import clock_generator_config_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	input wire logic slow_clk_in,
	input wire logic crystal_input_pin_in,
	output logic [31:0] periph_clk_en_out,
	output logic osc_enable_out,
	output logic osc_skip_out,
	output logic [1:0] pll_range_out,
	output logic mck_tick_out,
	output logic usb_tick_out
);
	function automatic logic rise(input logic now, input logic prev);
		return now & ~prev;
	endfunction
	function automatic logic [5:0] scale_mask(input logic [2:0] code);
		return 6'((7'h01 << code) - 7'h01);
	endfunction

	// bus and register group
	logic wr_pend, next_wr_pend;
	logic [7:0] wr_addr, next_wr_addr;
	logic [31:0] pcsr, next_pcsr;
	mor_t mor, next_mor;
	pllr_t pllr, next_pllr;
	mckr_t mckr, next_mckr;
	logic [31:0] rdata, next_rdata;
	logic rd_go;
	logic wr_mor, wr_pllr, wr_mckr;
	// oscillator, meter and pll group
	logic [2:0] slow_sync, main_sync;
	logic [11:0] osc_cnt, next_osc_cnt;
	logic osc_stable, next_osc_stable;
	logic meas_on, next_meas_on;
	logic [4:0] meas_slow, next_meas_slow;
	logic [15:0] meas_cnt, next_meas_cnt;
	logic [15:0] main_freq, next_main_freq;
	logic main_valid, next_main_valid;
	logic [5:0] lock_cnt, next_lock_cnt;
	logic lock_busy, next_lock_busy;
	logic locked, next_locked;
	logic [7:0] div_cnt, next_div_cnt;
	logic [12:0] pll_pend, next_pll_pend;
	logic [1:0] usb_cnt, next_usb_cnt;
	logic usb_tick, next_usb_tick;
	logic slow_tick, main_tick, div_tick, pll_tick;
	// master clock group
	mck_state_t mck_state, next_mck_state;
	logic [6:0] wait_cnt, next_wait_cnt;
	logic [5:0] scale_cnt, next_scale_cnt;
	logic mck_ok, next_mck_ok;
	logic mck_tick, next_mck_tick;
	logic src_tick;
	assign rd_go = hsel_in & htrans_in[1] & ~hwrite_in & hready_in;
	assign wr_mor = wr_pend && wr_addr == ADDR_MOR;
	assign wr_pllr = wr_pend && wr_addr == ADDR_PLLR;
	assign wr_mckr = wr_pend && wr_addr == ADDR_MCKR;
	// single wait-free slave: writes land in the data phase
	always_comb begin
		next_wr_pend = hsel_in & htrans_in[1] & hwrite_in & hready_in;
		next_wr_addr = haddr_in[7:0];
		next_pcsr = pcsr;
		next_mor = mor;
		next_pllr = pllr;
		next_mckr = mckr;
		if (wr_pend) begin
			case (wr_addr)
				ADDR_PCER: next_pcsr = pcsr | (hwdata_in & PERIPH_IMPL);
				ADDR_PCDR: next_pcsr = pcsr & ~(hwdata_in & PERIPH_IMPL);
				ADDR_MOR: next_mor = mor_t'(hwdata_in & MOR_WMASK);
				ADDR_PLLR: next_pllr = pllr_t'(hwdata_in & PLLR_WMASK);
				ADDR_MCKR: next_mckr = mckr_t'(hwdata_in & MCKR_WMASK);
				default: next_pcsr = pcsr;
			endcase
		end
		next_rdata = rdata;
		if (rd_go) begin
			case (haddr_in[7:0])
				ADDR_PCSR: next_rdata = pcsr;
				ADDR_MOR: next_rdata = 32'(mor);
				ADDR_MCFR: next_rdata = {15'h0000, main_valid, main_freq};
				ADDR_PLLR: next_rdata = 32'(pllr);
				ADDR_MCKR: next_rdata = 32'(mckr);
				ADDR_SR: next_rdata = (32'(osc_stable) << SR_OSC_BIT)
					| (32'(locked) << SR_LOCK_BIT) | (32'(mck_ok) << SR_MCK_BIT);
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			pcsr <= 32'h0000_0000;
			mor <= mor_t'(MOR_RESET);
			pllr <= pllr_t'(PLLR_RESET);
			mckr <= mckr_t'(MCKR_RESET);
			rdata <= 32'h0000_0000;
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else begin
			wr_pend <= next_wr_pend;
			wr_addr <= next_wr_addr;
			pcsr <= next_pcsr;
			mor <= next_mor;
			pllr <= next_pllr;
			mckr <= next_mckr;
			rdata <= next_rdata;
			hreadyout_out <= 1'b1; // the slave never stalls
			hresp_out <= 1'b0; // and never errors: every transfer is okay
		end
	end
	// pins are oversampled, so a main clock near the system rate is undercounted
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			slow_sync <= 3'h0;
			main_sync <= 3'h0;
		end else begin
			slow_sync <= {slow_sync[1:0], slow_clk_in};
			main_sync <= {main_sync[1:0], crystal_input_pin_in};
		end
	end
	assign slow_tick = rise(slow_sync[1], slow_sync[2]);
	assign main_tick = rise(main_sync[1], main_sync[2]);
	assign div_tick = (pllr.input_divider == 8'h01) ? main_tick :
		(pllr.input_divider != 8'h00 && main_tick && div_cnt == pllr.input_divider - 8'h01);
	assign pll_tick = pll_pend != 13'h0000;
	always_comb begin
		next_osc_cnt = osc_cnt;
		next_osc_stable = osc_stable;
		next_meas_on = meas_on;
		next_meas_slow = meas_slow;
		next_meas_cnt = meas_cnt;
		next_main_freq = main_freq;
		next_main_valid = main_valid;
		if (wr_mor) begin
			if (hwdata_in[1]) begin
				next_osc_stable = 1'b1;
				next_osc_cnt = 12'h000;
			end else if (hwdata_in[0] && !osc_stable) begin
				next_osc_cnt = 12'(hwdata_in[15:8]) << OSC_MULT_SHIFT;
			end else if (!hwdata_in[0]) begin
				next_osc_stable = 1'b0;
				next_osc_cnt = 12'h000;
				next_main_valid = 1'b0;
				next_meas_on = 1'b0;
			end
		end else if (mor.oscillator_enable_bit && !osc_stable && slow_tick) begin
			if (osc_cnt <= 12'h001) begin
				next_osc_stable = 1'b1;
				next_osc_cnt = 12'h000;
			end else begin
				next_osc_cnt = osc_cnt - 12'h001;
			end
		end
		// one measurement after each oscillator start, aligned to a slow edge
		if (!wr_mor && osc_stable && !main_valid) begin
			if (!meas_on && slow_tick) begin
				next_meas_on = 1'b1;
				next_meas_slow = 5'h00;
				next_meas_cnt = 16'h0000;
			end else if (meas_on) begin
				if (main_tick && meas_cnt != 16'hffff) begin
					next_meas_cnt = meas_cnt + 16'h0001;
				end
				if (slow_tick) begin
					next_meas_slow = meas_slow + 5'h01;
					if (meas_slow == MEAS_SLOW_PERIODS - 5'h01) begin
						next_meas_on = 1'b0;
						next_main_freq = next_meas_cnt;
						next_main_valid = 1'b1;
					end
				end
			end
		end
	end

	always_comb begin
		next_lock_cnt = lock_cnt;
		next_lock_busy = lock_busy;
		next_locked = locked;
		if (wr_pllr) begin
			next_lock_cnt = hwdata_in[13:8];
			next_lock_busy = 1'b1;
			next_locked = 1'b0;
		end else if (lock_busy && slow_tick) begin
			if (lock_cnt <= 6'h01) begin
				next_lock_busy = 1'b0;
				next_locked = 1'b1;
			end else begin
				next_lock_cnt = lock_cnt - 6'h01;
			end
		end
		next_div_cnt = div_cnt;
		if (main_tick) begin
			next_div_cnt = (div_tick || pllr.input_divider < 8'h02) ? 8'h00 : div_cnt + 8'h01;
		end
		// each divided input edge owes factor+1 output pulses
		next_pll_pend = pll_pend - (pll_tick ? 13'h0001 : 13'h0000);
		if (pllr.pll_feedback_factor == 11'h000) begin
			next_pll_pend = 13'h0000;
		end else if (div_tick) begin
			next_pll_pend = next_pll_pend + 13'(pllr.pll_feedback_factor) + 13'h0001;
		end
		next_usb_cnt = pll_tick ? usb_cnt + 2'h1 : usb_cnt;
		case (pllr.usb_clock_ratio)
			USB_DIV1: next_usb_tick = pll_tick;
			USB_DIV2: next_usb_tick = pll_tick && usb_cnt[0];
			USB_DIV4: next_usb_tick = pll_tick && usb_cnt == 2'h3;
			default: next_usb_tick = 1'b0;
		endcase
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			osc_cnt <= 12'h000;
			osc_stable <= 1'b0;
			meas_on <= 1'b0;
			meas_slow <= 5'h00;
			meas_cnt <= 16'h0000;
			main_freq <= 16'h0000;
			main_valid <= 1'b0;
			lock_cnt <= 6'h00;
			lock_busy <= 1'b0;
			locked <= 1'b0;
			div_cnt <= 8'h00;
			pll_pend <= 13'h0000;
			usb_cnt <= 2'h0;
			usb_tick <= 1'b0;
		end else begin
			osc_cnt <= next_osc_cnt;
			osc_stable <= next_osc_stable;
			meas_on <= next_meas_on;
			meas_slow <= next_meas_slow;
			meas_cnt <= next_meas_cnt;
			main_freq <= next_main_freq;
			main_valid <= next_main_valid;
			lock_cnt <= next_lock_cnt;
			lock_busy <= next_lock_busy;
			locked <= next_locked;
			div_cnt <= next_div_cnt;
			pll_pend <= next_pll_pend;
			usb_cnt <= next_usb_cnt;
			usb_tick <= next_usb_tick;
		end
	end

	always_comb begin
		case (mckr.source_select)
			SRC_SLOW: src_tick = slow_tick;
			SRC_MAIN: src_tick = main_tick;
			SRC_PLL: src_tick = pll_tick;
			default: src_tick = 1'b0;
		endcase
	end

	// output pulses stay off during a switch, so no short period escapes
	always_comb begin
		next_mck_state = mck_state;
		next_wait_cnt = wait_cnt;
		next_scale_cnt = scale_cnt;
		next_mck_ok = mck_ok;
		next_mck_tick = 1'b0;
		if (wr_mckr) begin
			next_mck_state = MCK_SYNC;
			next_mck_ok = 1'b0;
			next_wait_cnt = 7'h00;
			next_scale_cnt = 6'h00;
		end else begin
			case (mck_state)
				MCK_RUN: begin
					if (src_tick && mckr.master_clock_scaler != SCALER_RSVD) begin
						next_scale_cnt = scale_cnt + 6'h01;
						next_mck_tick = (scale_cnt & scale_mask(mckr.master_clock_scaler))
							== scale_mask(mckr.master_clock_scaler);
					end
				end
				MCK_SYNC: begin
					// a reserved scaler delivers no clock, so ready stays low
					if (src_tick && mckr.master_clock_scaler != SCALER_RSVD) begin
						next_wait_cnt = wait_cnt + 7'h01;
						if (wait_cnt == MCK_SYNC_TICKS - 7'h01) begin
							next_wait_cnt = 7'h00;
							if (mckr.master_clock_scaler == 3'h0) begin
								next_mck_state = MCK_RUN;
								next_mck_ok = 1'b1;
							end else begin
								next_mck_state = MCK_EXTRA;
							end
						end
					end
				end
				MCK_EXTRA: begin
					if (src_tick) begin
						next_wait_cnt = wait_cnt + 7'h01;
						if (wait_cnt == MCK_EXTRA_TICKS - 7'h01) begin
							next_mck_state = MCK_RUN;
							next_mck_ok = 1'b1;
						end
					end
				end
				default: next_mck_state = MCK_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			mck_state <= MCK_RUN;
			wait_cnt <= 7'h00;
			scale_cnt <= 6'h00;
			mck_ok <= 1'b1;
			mck_tick <= 1'b0;
		end else begin
			mck_state <= next_mck_state;
			wait_cnt <= next_wait_cnt;
			scale_cnt <= next_scale_cnt;
			mck_ok <= next_mck_ok;
			mck_tick <= next_mck_tick;
		end
	end

	assign hrdata_out = rdata;
	assign periph_clk_en_out = pcsr;
	assign osc_enable_out = mor.oscillator_enable_bit;
	assign osc_skip_out = mor.oscillator_skip_bit;
	assign pll_range_out = pllr.freq_range;
	assign mck_tick_out = mck_tick;
	assign usb_tick_out = usb_tick;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	AST_PCER_SETS: assert property (wr_pend && wr_addr == ADDR_PCER |=>
		(periph_clk_en_out & $past(hwdata_in) & PERIPH_IMPL) == ($past(hwdata_in) & PERIPH_IMPL))
		else $error("gating set write did not enable clocks");
	AST_PCDR_CLEARS: assert property (wr_pend && wr_addr == ADDR_PCDR |=>
		(periph_clk_en_out & $past(hwdata_in) & PERIPH_IMPL) == 32'h0000_0000)
		else $error("gating clear write did not disable clocks");
	AST_PCSR_READ: assert property (rd_go && haddr_in[7:0] == ADDR_PCSR |=>
		hrdata_out == $past(periph_clk_en_out))
		else $error("gating status read mismatch");
	AST_UNIMPL_QUIET: assert property ((periph_clk_en_out & ~PERIPH_IMPL) == 32'h0000_0000)
		else $error("unimplemented gating bit set");
	AST_SKIP_STABLE: assert property (wr_mor && hwdata_in[1] |=> osc_stable)
		else $error("skip bit did not set stable flag");
	AST_OSC_OFF: assert property (wr_mor && hwdata_in[1:0] == 2'h0 |=> !osc_stable
		##1 (!osc_stable || $past(wr_mor))) else $error("stable flag not cleared");
	AST_VALID_OFF: assert property (!(osc_enable_out || osc_skip_out) |-> !main_valid)
		else $error("measurement valid with oscillator off");
	AST_LOCK_DROP: assert property (wr_pllr |=> !locked)
		else $error("lock flag high right after pll write");
	AST_LOCK_EDGE: assert property ($rose(locked) |->
		$past(lock_busy) && $past(slow_tick)) else $error("lock flag rose off a slow edge");
	AST_MCK_QUIET: assert property (wr_mckr |=> !mck_ok && !mck_tick_out)
		else $error("master clock ready during switch");
	AST_EXTRA_WAIT: assert property ($rose(mck_ok) && mckr.master_clock_scaler != 3'h0
		|-> $past(mck_state) == MCK_EXTRA)
		else $error("scaled switch skipped the extra wait");
endmodule // clock_generator_config
`default_nettype wire

// File: logic/clock_generator_config_pkg.sv
// Purpose: constants, register layouts and states of the clock generator
// Assumes: 32-bit AHB-Lite register port, one system clock
// Notes: offsets are byte addresses within the block
`default_nettype none
package clock_generator_config_pkg;
	localparam logic [7:0] ADDR_PCER = 8'h10;
	localparam logic [7:0] ADDR_PCDR = 8'h14;
	localparam logic [7:0] ADDR_PCSR = 8'h18;
	localparam logic [7:0] ADDR_MOR = 8'h20;
	localparam logic [7:0] ADDR_MCFR = 8'h24;
	localparam logic [7:0] ADDR_PLLR = 8'h2c;
	localparam logic [7:0] ADDR_MCKR = 8'h30;
	localparam logic [7:0] ADDR_SR = 8'h68;
	// peripheral identifiers 2 to 15 are implemented
	localparam logic [31:0] PERIPH_IMPL = 32'h0000_fffc;
	localparam logic [31:0] MOR_RESET = 32'h0000_0000;
	localparam logic [31:0] PLLR_RESET = 32'h0000_3f00;
	localparam logic [31:0] MCKR_RESET = 32'h0000_0000;
	localparam logic [31:0] MOR_WMASK = 32'h0000_ff03;
	localparam logic [31:0] PLLR_WMASK = 32'h37ff_ffff;
	localparam logic [31:0] MCKR_WMASK = 32'h0000_001f;
	localparam int SR_OSC_BIT = 0;
	localparam int SR_LOCK_BIT = 2;
	localparam int SR_MCK_BIT = 3;
	localparam int OSC_MULT_SHIFT = 3;
	localparam logic [4:0] MEAS_SLOW_PERIODS = 5'h10;
	localparam logic [6:0] MCK_SYNC_TICKS = 7'h02;
	localparam logic [6:0] MCK_EXTRA_TICKS = 7'h40;
	localparam logic [1:0] SRC_SLOW = 2'h0;
	localparam logic [1:0] SRC_MAIN = 2'h1;
	localparam logic [1:0] SRC_PLL = 2'h3;
	localparam logic [2:0] SCALER_RSVD = 3'h7;
	localparam logic [1:0] USB_DIV1 = 2'h0;
	localparam logic [1:0] USB_DIV2 = 2'h1;
	localparam logic [1:0] USB_DIV4 = 2'h2;

	typedef struct packed {
		logic [15:0] unused_hi;
		logic [7:0] osc_startup_delay;
		logic [5:0] unused_lo;
		logic oscillator_skip_bit;
		logic oscillator_enable_bit;
	} mor_t;

	typedef struct packed {
		logic [1:0] unused_hi;
		logic [1:0] usb_clock_ratio;
		logic unused_mid;
		logic [10:0] pll_feedback_factor;
		logic [1:0] freq_range;
		logic [5:0] pll_settle_delay;
		logic [7:0] input_divider;
	} pllr_t;

	typedef struct packed {
		logic [26:0] unused_hi;
		logic [2:0] master_clock_scaler;
		logic [1:0] source_select;
	} mckr_t;

	typedef enum logic [1:0] {
		MCK_RUN = 2'b00,
		MCK_SYNC = 2'b01,
		MCK_EXTRA = 2'b10
	} mck_state_t;
endpackage
`default_nettype wire

// File: verification/testbench.sv
// Purpose: self-checking bench for the clock generator configuration block
// Assumes: hreadyout is fed back as hready; slow and main pins are made here
// Notes: pins are made from the system clock but edge-detected in the design, so timing checks allow some slack
`default_nettype none
module testbench import clock_generator_config_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 1'b0;
	logic srst_in = 1'b1;
	logic hsel_in = 1'b0;
	logic hwrite_in = 1'b0;
	logic [1:0] htrans_in = 2'h0;
	logic [31:0] haddr_in = 32'h0;
	logic [31:0] hwdata_in = 32'h0;
	logic slow_clk_in = 1'b0;
	logic crystal_input_pin_in = 1'b0;
	logic [31:0] hrdata_out;
	logic [31:0] periph_clk_en_out;
	logic hreadyout_out;
	logic hresp_out;
	logic osc_enable_out;
	logic osc_skip_out;
	logic mck_tick_out;
	logic usb_tick_out;
	logic [1:0] pll_range_out;
	int mismatches = 0;
	int checks = 0;
	int cyc = 0;
	int slow_edges = 0;
	int usb_n = 0;
	int mck_n = 0;
	logic [31:0] seed = 32'hcf9846c9;
	logic [7:0] ra [7] = '{ADDR_PCSR, ADDR_MOR, ADDR_MCFR, ADDR_PLLR, ADDR_MCKR, ADDR_SR, 8'h28};
	logic [31:0] rv [7] = '{32'h0, MOR_RESET, 32'h0, PLLR_RESET, MCKR_RESET, 32'h8, 32'h0};
	logic [7:0] pd [8] = '{8'h1, 8'h1, 8'h1, 8'h1, 8'h2, 8'h2, 8'h0, 8'h1};
	logic [10:0] pm [8] = '{11'h1, 11'h1, 11'h1, 11'h1, 11'h1, 11'h2, 11'h1, 11'h0};
	logic [1:0] pu [8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};
	logic [1:0] ms [7] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h1, 2'h3, 2'h1};
	logic [2:0] mp [7] = '{3'h0, 3'h2, 3'h0, 3'h0, 3'h7, 3'h1, 3'h6};

	clock_generator_config u_dut (
		.clk_sys_in(clk_sys_in),
		.srst_in(srst_in),
		.hsel_in(hsel_in),
		.haddr_in(haddr_in),
		.htrans_in(htrans_in),
		.hwrite_in(hwrite_in),
		.hsize_in(3'h2),
		.hwdata_in(hwdata_in),
		.hready_in(hreadyout_out),
		.hrdata_out(hrdata_out),
		.hreadyout_out(hreadyout_out),
		.hresp_out(hresp_out),
		.slow_clk_in(slow_clk_in),
		.crystal_input_pin_in(crystal_input_pin_in),
		.periph_clk_en_out(periph_clk_en_out),
		.osc_enable_out(osc_enable_out),
		.osc_skip_out(osc_skip_out),
		.pll_range_out(pll_range_out),
		.mck_tick_out(mck_tick_out),
		.usb_tick_out(usb_tick_out)
	);

	initial begin
		forever #20 clk_sys_in = ~clk_sys_in;
	end

	// slow pin period 40 cycles, main pin period 8 cycles
	always @(posedge clk_sys_in) begin
		cyc <= cyc + 1;
		slow_clk_in <= (cyc % 40) >= 20;
		crystal_input_pin_in <= (cyc % 8) >= 4;
		if (cyc % 40 == 19) slow_edges <= slow_edges + 1;
		if (usb_tick_out === 1'b1) usb_n <= usb_n + 1;
		if (mck_tick_out === 1'b1) mck_n <= mck_n + 1;
		if (cyc == 40000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic conclude();
		if (mismatches == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi, input int s);
		checks++;
		if (s < lo || s > hi) begin
			mismatches++;
			$display("unexpected %s expected %0d..%0d seen %0d", nm, lo, hi, s);
		end
	endtask

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// one single transfer; hready is sampled high before each phase ends
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd,
		output logic [31:0] rd_v);
		hsel_in <= 1'b1;
		htrans_in <= 2'h2;
		haddr_in <= {24'h0, a};
		hwrite_in <= wr;
		@(posedge clk_sys_in);
		while (hreadyout_out !== 1'b1) @(posedge clk_sys_in);
		htrans_in <= 2'h0;
		hsel_in <= 1'b0;
		hwdata_in <= wd;
		@(posedge clk_sys_in);
		while (hreadyout_out !== 1'b1) @(posedge clk_sys_in);
		rd_v = hrdata_out;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(a, 1'b1, d, x);
		@(posedge clk_sys_in);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		bus(a, 1'b0, 32'h0, v);
	endtask

	// bounded wait for a status bit, measured in cycles and slow edges
	task automatic poll(input logic [7:0] a, input int b, output int dc, output int ds);
		int c0;
		int s0;
		logic [31:0] v;
		c0 = cyc;
		s0 = slow_edges;
		v = 32'h0;
		while (v[b] !== 1'b1 && cyc - c0 < 3000) rd(a, v);
		dc = cyc - c0;
		ds = slow_edges - s0;
	endtask

	function automatic int usb_exp(int i);
		if (pd[i] == 0 || pm[i] == 0 || pu[i] == 3) return 0;
		return ((100 / pd[i]) * (pm[i] + 1)) >> pu[i];
	endfunction

	function automatic int mck_exp(int i);
		int r;
		r = (ms[i] == 2'h0) ? 20 : (ms[i] == 2'h1) ? 100 : (ms[i] == 2'h3) ? 200 : 0;
		return (mp[i] == 3'h7) ? 0 : r >> mp[i];
	endfunction

	initial begin
		logic [31:0] v;
		logic [31:0] w;
		logic [31:0] st;
		int dc;
		int ds;
		int n0;
		repeat (2) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd(ra[i], v);
			chk("reset value", rv[i], v);
			chk("okay response", 32'h0, {31'h0, hresp_out});
		end
		st = 32'h0;
		for (int i = 0; i < 8; i++) begin
			w = (i == 0) ? 32'hffff_ffff : rnd();
			wr(ADDR_PCER, w);
			st = st | (w & PERIPH_IMPL);
			wr(ADDR_PCSR, ~st);
			rd(ADDR_PCSR, v);
			chk("gating after set", st, v);
			w = (i == 7) ? 32'hffff_ffff : rnd();
			wr(ADDR_PCDR, w);
			st = st & ~w;
			rd(ADDR_PCSR, v);
			chk("gating after clear", st, v);
			chk("gating enables", st, periph_clk_en_out);
		end
		wr(ADDR_MOR, 32'h0000_0002);
		rd(ADDR_SR, v);
		chk("stable by skip", 32'h1, {31'h0, v[SR_OSC_BIT]});
		chk("skip pin", 32'h1, {31'h0, osc_skip_out});
		wr(ADDR_MOR, 32'h0);
		rd(ADDR_SR, v);
		chk("stable cleared", 32'h0, {31'h0, v[SR_OSC_BIT]});
		rd(ADDR_MCFR, v);
		chk("count valid off", 32'h0, {31'h0, v[16]});
		// delay field 2 gives 16 slow edges
		wr(ADDR_MOR, 32'h0000_0201);
		poll(ADDR_SR, SR_OSC_BIT, dc, ds);
		chk_rng("startup slow edges", 15, 17, ds);
		chk("enable pin", 32'h1, {31'h0, osc_enable_out});
		poll(ADDR_MCFR, 16, dc, ds);
		rd(ADDR_MCFR, v);
		chk("count valid on", 32'h1, {31'h0, v[16]});
		chk_rng("main count", 78, 82, int'(v[15:0]));
		for (int i = 0; i < 8; i++) begin
			w = {2'h0, pu[i], 1'b0, pm[i], 2'(rnd()), 6'h3, pd[i]};
			wr(ADDR_PLLR, w);
			poll(ADDR_SR, SR_LOCK_BIT, dc, ds);
			chk_rng("lock slow edges", 2, 4, ds);
			rd(ADDR_PLLR, v);
			chk("pll config", w & PLLR_WMASK, v);
			chk("pll range pin", {30'h0, w[15:14]}, {30'h0, pll_range_out});
			n0 = usb_n;
			repeat (800) @(posedge clk_sys_in);
			chk_rng("usb ticks", usb_exp(i) - 4, usb_exp(i) + 4, usb_n - n0);
		end
		wr(ADDR_PLLR, 32'h0001_0301);
		poll(ADDR_SR, SR_LOCK_BIT, dc, ds);
		for (int i = 0; i < 7; i++) begin
			w = {27'h0, mp[i], ms[i]};
			wr(ADDR_MCKR, w);
			rd(ADDR_SR, v);
			chk("ready dropped", 32'h0, {31'h0, v[SR_MCK_BIT]});
			rd(ADDR_MCKR, v);
			chk("master config", w & MCKR_WMASK, v);
			if (mck_exp(i) > 0) begin
				poll(ADDR_SR, SR_MCK_BIT, dc, ds);
				n0 = (mp[i] != 3'h0) ? 528 : 16;
				if (ms[i] == SRC_MAIN) chk_rng("switch cycles", n0 - 20, n0 + 24, dc);
			end
			n0 = mck_n;
			repeat (800) @(posedge clk_sys_in);
			chk_rng("master ticks", mck_exp(i) - 3, mck_exp(i) + 3, mck_n - n0);
			rd(ADDR_SR, v);
			chk("ready level", {31'h0, mck_exp(i) > 0}, {31'h0, v[SR_MCK_BIT]});
		end
		conclude();
	end
endmodule // testbench
`default_nettype wire
